/* File: inc/tpg_pkg.sv */
/*
 * Shared constants and types for the video test pattern generator.
 * Assumes a 100 MHz core clock and a byte-wide CSI-2 packet stream.
 */
package tpg_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_CSI      = 8'h04;
  localparam logic [7:0] REG_LINE_LEN = 8'h08;
  localparam logic [7:0] REG_BAR_W    = 8'h0c;
  localparam logic [7:0] REG_ACT_LPF  = 8'h10;
  localparam logic [7:0] REG_TOT_LPF  = 8'h14;
  localparam logic [7:0] REG_LINE_PD  = 8'h18;
  localparam logic [7:0] REG_VBP      = 8'h1c;
  localparam logic [7:0] REG_VFP      = 8'h20;
  localparam logic [7:0] REG_BLK_SIZE = 8'h24;
  localparam logic [7:0] REG_STATUS   = 8'h28;
  localparam logic [1:0] FIX_PAGE     = 2'b01;  // 0x40..0x7c

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_MODE_BIT = 1;  // 0 bars, 1 fixed
  localparam int CTRL_BARS_LSB = 2;  // log2 of bar count
  localparam logic [3:0] CTRL_RST  = 4'hc;
  localparam logic [4:0] BLK_RST   = 5'h01;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // Bar bytes, bar 0 in the low byte
  localparam logic [63:0] BAR_BYTES = 64'h800f_cc55_7ff0_33aa;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINE_UNIT_NS  = 10;
  localparam int CYC_PER_UNIT  = LINE_UNIT_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PK_FS  = 2'b00,
    PK_FE  = 2'b01,
    PK_HDR = 2'b10,
    PK_PAY = 2'b11
  } tpg_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_FS   = 3'b010,
    ST_HDR  = 3'b011,
    ST_DATA = 3'b100
  } tpg_state_e;

  typedef struct packed {
    logic        valid;
    tpg_kind_e   kind;
    logic        last;
    logic [1:0]  vc;
    logic [5:0]  dt;
    logic [15:0] wc;
    logic [7:0]  data;
  } tpg_beat_s;

endpackage

/* File: hw/tpg_generator.sv */
/*
 * Test pattern generator: builds CSI-2 frames of color bars or a
 * repeating fixed byte block, configured over Avalon-MM.
 * Assumes the transmitter shares core_clk and takes one beat per
 * cycle while txReady is high.
 */
// Local design decisions: the address map and the Avalon-MM register port.
// Behaviour
// - Bar bytes AA,33,F0,7F,55,CC,0F then 80 for the last bar (eight bars; with four, two or one bar the last bar is 0F, 55 or AA).
// - Reset configuration gives eight bars per active line.
// - Bars span bar width; the last bar fills to line length.
// - Bar count selectable as one, two, four or eight.
// - Line length and bar width are separate settings.
// - Datatype and virtual channel go into produced packets.
// - Active lines and total lines per frame set frame length.
// - Line start spacing is a line period in 10 ns units.
// - Front porch blank lines come before frame end.
// - Back porch blank lines follow frame start.
// - Runs on the transmit clock, hands formatted beats out.
// - Fixed mode repeats programmable bytes, same geometry.
// - Fixed mode inverts the bytes on every other bar.
// - Block length one to sixteen bytes, repeated along line.
// - Sixteen byte registers hold the fixed block.
// - Fixed block bytes sit on page 0x40, all other settings on page 0.
`timescale 1ns/1ns
`default_nettype none

module tpg_generator
  import tpg_pkg::*;
(
  input  wire logic        core_clk,        // Transmit clock
  input  wire logic        rst,             // Sync reset, high
  input  wire logic [7:0]  avs_address,     // Byte address
  input  wire logic        avs_read,        // Read request
  input  wire logic        avs_write,       // Write request
  input  wire logic [31:0] avs_writedata,   // Write data
  input  wire logic [3:0]  avs_byteenable,  // Byte lanes
  output logic      [31:0] avs_readdata,    // Read data
  output logic             avs_waitrequest, // Stall
  input  wire logic        txReady,         // Transmitter takes beat
  output var tpg_beat_s    txBeat           // Packet beat out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] beMerge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [3:0]  ctrlQ;
  logic [7:0]  csiQ;
  logic [15:0] lineLenQ, barWQ, actQ, totQ, linePdQ;
  logic [7:0]  vbpQ, vfpQ;
  logic [4:0]  blkQ;
  logic [7:0]  fixQ [16];
  logic        waitQ;
  logic [31:0] rdQ, rdMux;
  tpg_beat_s   beatQ;
  tpg_state_e  stateQ;
  logic [15:0] lineIdxQ, frameCntQ, byteCntQ, barPosQ;
  logic [2:0]  barIdxQ;
  logic [3:0]  blkPosQ;
  logic        actLineQ, pendQ;
  logic [15:0] tmrQ;
  logic [7:0]  prescQ;

  logic        wrAcc, en, advance, lineTake, unitTick;
  logic [31:0] wm;
  logic [15:0] actEnd, feLine;
  logic        isActive, lastBar;
  logic [2:0]  lastBarIdx, colorIdx;
  logic [7:0]  payByte;

  assign en    = ctrlQ[CTRL_EN_BIT];
  assign wrAcc = avs_write && !waitQ;
  assign avs_waitrequest = waitQ;
  assign avs_readdata    = rdQ;
  assign txBeat          = beatQ;

  // Merge of the write data over the addressed word
  always_comb begin
    wm = beMerge(rdMux, avs_writedata, avs_byteenable);
  end

  // ----------------------------------------------------------------
  // Avalon handshake: one wait cycle, answer on the second
  // ----------------------------------------------------------------
  // Read data is latched with the wait cycle so it is a flop output
  always_ff @(posedge core_clk) begin
    if (rst) begin
      waitQ <= 1'b1;
      rdQ   <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && waitQ) begin
      waitQ <= 1'b0;
      rdQ   <= avs_read ? rdMux : 32'h0000_0000;
    end else begin
      waitQ <= 1'b1;
    end
  end

  // Read decode; unmapped offsets read zero
  always_comb begin
    rdMux = 32'h0000_0000;
    if (avs_address[7:6] == FIX_PAGE) begin
      rdMux[7:0] = fixQ[avs_address[5:2]];
    end else begin
      case (avs_address)
        REG_CTRL:     rdMux[3:0]  = ctrlQ;
        REG_CSI:      rdMux[7:0]  = csiQ;
        REG_LINE_LEN: rdMux[15:0] = lineLenQ;
        REG_BAR_W:    rdMux[15:0] = barWQ;
        REG_ACT_LPF:  rdMux[15:0] = actQ;
        REG_TOT_LPF:  rdMux[15:0] = totQ;
        REG_LINE_PD:  rdMux[15:0] = linePdQ;
        REG_VBP:      rdMux[7:0]  = vbpQ;
        REG_VFP:      rdMux[7:0]  = vfpQ;
        REG_BLK_SIZE: rdMux[4:0]  = blkQ;
        REG_STATUS:   rdMux = {lineIdxQ, frameCntQ[12:0], stateQ};
        default:      rdMux = 32'h0000_0000;
      endcase
    end
  end

  // Configuration writes, taken at the edge that ends the wait-low cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrlQ    <= CTRL_RST;
      csiQ     <= 8'h00;
      lineLenQ <= WORD_RST;
      barWQ    <= WORD_RST;
      actQ     <= WORD_RST;
      totQ     <= WORD_RST;
      linePdQ  <= WORD_RST;
      vbpQ     <= 8'h00;
      vfpQ     <= 8'h00;
      blkQ     <= BLK_RST;
    end else if (wrAcc && avs_address[7:6] != FIX_PAGE) begin
      case (avs_address)
        REG_CTRL:     ctrlQ    <= wm[3:0];
        REG_CSI:      csiQ     <= wm[7:0];
        REG_LINE_LEN: lineLenQ <= wm[15:0];
        REG_BAR_W:    barWQ    <= wm[15:0];
        REG_ACT_LPF:  actQ     <= wm[15:0];
        REG_TOT_LPF:  totQ     <= wm[15:0];
        REG_LINE_PD:  linePdQ  <= wm[15:0];
        REG_VBP:      vbpQ     <= wm[7:0];
        REG_VFP:      vfpQ     <= wm[7:0];
        REG_BLK_SIZE: blkQ     <= wm[4:0];
        default:      ;
      endcase
    end
  end

  // Fixed block bytes, one register per byte position
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        fixQ[i] <= 8'h00;
      end
    end else if (wrAcc && avs_address[7:6] == FIX_PAGE) begin
      fixQ[avs_address[5:2]] <= wm[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Line timing
  // ----------------------------------------------------------------
  // Divider gives one enable per 10 ns unit when CLK_PERIOD_NS divides 10
  assign unitTick = (prescQ == 8'(CYC_PER_UNIT - 1));

  always_ff @(posedge core_clk) begin
    if (rst || !en) begin
      prescQ <= 8'h00;
    end else begin
      prescQ <= unitTick ? 8'h00 : 8'(prescQ + 8'h01);
    end
  end

  // Timer starts at zero so the first line begins on enable
  always_ff @(posedge core_clk) begin
    if (rst || !en) begin
      tmrQ <= 16'h0000;
    end else if (unitTick) begin
      if (tmrQ == 16'h0000) begin
        tmrQ <= (linePdQ == 16'h0000) ? 16'h0000
                : 16'(linePdQ - 16'h0001);
      end else begin
        tmrQ <= 16'(tmrQ - 16'h0001);
      end
    end
  end

  // Pending line start; a new start wins over the take
  always_ff @(posedge core_clk) begin
    if (rst || !en) begin
      pendQ <= 1'b0;
    end else if (unitTick && tmrQ == 16'h0000) begin
      pendQ <= 1'b1;
    end else if (lineTake) begin
      pendQ <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  // Line 0 opens with frame start, then back porch, active, front
  assign actEnd   = 16'(16'(vbpQ) + actQ);
  assign feLine   = 16'(actEnd + 16'(vfpQ));
  assign isActive = (lineIdxQ >= 16'(vbpQ)) && (lineIdxQ < actEnd);
  assign advance  = en && (!beatQ.valid || txReady);
  assign lineTake = advance && stateQ == ST_WAIT && pendQ;

  // ----------------------------------------------------------------
  // Byte pattern
  // ----------------------------------------------------------------
  // Fewer bars spread over the table so one bar shows 0xaa alone
  always_comb begin
    lastBarIdx = 3'(4'(4'h1 << ctrlQ[3:2]) - 4'h1);
    lastBar    = (barIdxQ == lastBarIdx);
    colorIdx   = 3'(barIdxQ << (2'd3 - ctrlQ[3:2]));
    if (ctrlQ[CTRL_MODE_BIT]) begin
      payByte = fixQ[blkPosQ] ^ {8{barIdxQ[0]}};
    end else begin
      payByte = BAR_BYTES[{colorIdx, 3'b000} +: 8];
    end
  end

  // ----------------------------------------------------------------
  // Packet sequencer
  // ----------------------------------------------------------------
  // Disable clears state and beat on the next edge; a beat loaded at the disabling write's edge can still be taken
  always_ff @(posedge core_clk) begin
    if (rst || !en) begin
      stateQ    <= ST_IDLE;
      beatQ     <= '0;
      lineIdxQ  <= 16'h0000;
      frameCntQ <= 16'h0000;
      actLineQ  <= 1'b0;
    end else if (advance) begin
      beatQ.valid <= 1'b0;
      case (stateQ)
        ST_IDLE: begin
          stateQ <= ST_WAIT;
        end
        ST_WAIT: begin
          if (pendQ) begin
            actLineQ <= isActive;
            lineIdxQ <= (lineIdxQ + 16'h0001 >= totQ) ? 16'h0000
                        : 16'(lineIdxQ + 16'h0001);
            if (lineIdxQ == 16'h0000) begin
              stateQ <= ST_FS;
            end else if (lineIdxQ == feLine) begin
              beatQ <= '{1'b1, PK_FE, 1'b1, csiQ[7:6], 6'h01,
                         frameCntQ, 8'h00};
              frameCntQ <= 16'(frameCntQ + 16'h0001);
            end else if (isActive) begin
              stateQ <= ST_HDR;
            end
          end
        end
        ST_FS: begin
          beatQ  <= '{1'b1, PK_FS, 1'b1, csiQ[7:6], 6'h00,
                      frameCntQ, 8'h00};
          stateQ <= actLineQ ? ST_HDR : ST_WAIT;
        end
        ST_HDR: begin
          // Long packet header carries the programmed identifiers
          beatQ  <= '{1'b1, PK_HDR, 1'b0, csiQ[7:6], csiQ[5:0],
                      lineLenQ, 8'h00};
          stateQ <= (lineLenQ == 16'h0000) ? ST_WAIT : ST_DATA;
        end
        ST_DATA: begin
          beatQ <= '{1'b1, PK_PAY, byteCntQ + 16'h0001 == lineLenQ,
                     csiQ[7:6], csiQ[5:0], lineLenQ, payByte};
          if (byteCntQ + 16'h0001 >= lineLenQ) begin
            stateQ <= ST_WAIT;
          end
        end
        default: stateQ <= ST_IDLE;
      endcase
    end
  end

  // Byte, bar and block position counters within a line
  always_ff @(posedge core_clk) begin
    if (rst || !en || (advance && stateQ == ST_HDR)) begin
      byteCntQ <= 16'h0000;
      barPosQ  <= 16'h0000;
      barIdxQ  <= 3'h0;
      blkPosQ  <= 4'h0;
    end else if (advance && stateQ == ST_DATA) begin
      byteCntQ <= 16'(byteCntQ + 16'h0001);
      // Last bar never wraps, so it runs to line end
      if (!lastBar && barPosQ + 16'h0001 >= barWQ) begin
        barPosQ <= 16'h0000;
        barIdxQ <= 3'(barIdxQ + 3'h1);
      end else begin
        barPosQ <= 16'(barPosQ + 16'h0001);
      end
      // Zero block size behaves as one byte
      if ({1'b0, blkPosQ} + 5'h01 >= blkQ) begin
        blkPosQ <= 4'h0;
      end else begin
        blkPosQ <= 4'(blkPosQ + 4'h1);
      end
    end
  end

endmodule

`default_nettype wire

/* File: verification/tpg_gen_sva.sv */
/* Port checker for tpg_generator.
   Assumes it is bound onto every generator instance. */
`timescale 1ns/1ns
`default_nettype none
module tpg_gen_sva
  import tpg_pkg::*;
(
  input wire logic        core_clk,        // Clock
  input wire logic        rst,             // Sync reset
  input wire logic        avs_read,        // Read request
  input wire logic        avs_write,       // Write request
  input wire logic [31:0] avs_readdata,    // Read data
  input wire logic        avs_waitrequest, // Stall
  input wire logic        txReady,         // Sink takes beat
  input wire tpg_beat_s   txBeat           // Beat out
);
  // ------------------------------------------------------------
  // Bus and stream relations
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_ack;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
  property p_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("wait low too long");
  property p_rdhold;
    !avs_read && !avs_write |=> $stable(avs_readdata);
  endproperty
  a_rdhold: assert property (p_rdhold) else $error("read data moved");
  // Abort by a control write may drop a held beat
  property p_hold;
    txBeat.valid && !txReady && !avs_write && !$past(avs_write) |=> $stable(txBeat);
  endproperty
  a_hold: assert property (p_hold) else $error("beat changed while stalled");
  property p_fs;
    txBeat.valid && txBeat.kind == PK_FS |-> txBeat.last && txBeat.dt == 6'h00;
  endproperty
  a_fs: assert property (p_fs) else $error("bad frame start");
  property p_fe;
    txBeat.valid && txBeat.kind == PK_FE |-> txBeat.last && txBeat.dt == 6'h01;
  endproperty
  a_fe: assert property (p_fe) else $error("bad frame end");
  property p_hdrpay;
    txBeat.valid && txReady && txBeat.kind == PK_HDR && !avs_write && !$past(avs_write)
      |=> ##[0:3] (txBeat.valid && txBeat.kind == PK_PAY);
  endproperty
  a_hdrpay: assert property (p_hdrpay) else $error("header without payload");
  property p_paywc;
    txBeat.valid && txReady && txBeat.kind == PK_PAY && !txBeat.last
      |=> !txBeat.valid || (txBeat.kind == PK_PAY && txBeat.wc == $past(txBeat.wc));
  endproperty
  a_paywc: assert property (p_paywc) else $error("payload cut short");
endmodule
bind tpg_generator tpg_gen_sva chk_u (.core_clk(core_clk), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .txReady(txReady), .txBeat(txBeat));
`default_nettype wire

/* File: verification/tpg_tx_model.sv */
/* Transmitter stand-in: takes beats, logs them with cycle stamps.
   Assumes the bench reads and clears the logs. */
`timescale 1ns/1ns
`default_nettype none
module tpg_tx_model
  import tpg_pkg::*;
(
  input  wire logic      core_clk, // Clock
  input  wire logic      rst,      // Sync reset
  input  wire logic      stall,    // Throttle on
  input  wire tpg_beat_s txBeat,   // Beat in
  output var logic       txReady   // Take beat
);
  tpg_beat_s  beats[$]; // Accepted beats
  int         stamp[$]; // Accept cycle
  int         cyc = 0;
  logic [1:0] ph_q = 2'h0;
  // ------------------------------------------------------------
  // One refusal in four when throttled, to exercise holding
  // ------------------------------------------------------------
  always_comb txReady = !rst && !(stall && ph_q == 2'h3);
  always @(posedge core_clk) begin
    ph_q <= ph_q + 2'h1;
    cyc <= cyc + 1;
    if (!rst && txBeat.valid === 1'b1 && txReady) begin
      beats.push_back(txBeat);
      stamp.push_back(cyc);
    end
  end
endmodule
`default_nettype wire

/* File: verification/tpg_generator_tb_top.sv */
/* Self-checking bench for tpg_generator over Avalon-MM.
   Assumes the transmitter model and bound checker are compiled. */
`timescale 1ns/1ns
`default_nettype none
module tpg_generator_tb_top
  import tpg_pkg::*;
;
  localparam int LEN = 27;
  localparam int ACT = 2;
  localparam int TOT = 5;
  localparam int PD  = 60;
  localparam int FB  = 2 + ACT * (LEN + 1);
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  busAddr = 8'h00;
  logic        busRd = 1'b0;
  logic        busWr = 1'b0;
  logic [31:0] busWdata = 32'h0;
  logic [31:0] busRdata;
  logic        busWait;
  logic        stall = 1'b0;
  logic        txReady;
  tpg_beat_s   txBeat;
  int          fail_count = 0;
  int          cmp_count = 0;
  logic [31:0] junk;

  always #5 core_clk = ~core_clk;
  tpg_generator dut_u (.core_clk(core_clk), .rst(rst), .avs_address(busAddr), .avs_read(busRd),
    .avs_write(busWr), .avs_writedata(busWdata), .avs_byteenable(4'hf), .avs_readdata(busRdata),
    .avs_waitrequest(busWait), .txReady(txReady), .txBeat(txBeat));
  tpg_tx_model tx_u (.core_clk(core_clk), .rst(rst), .stall(stall), .txBeat(txBeat), .txReady(txReady));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic close_out();
    if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    busAddr <= a;
    busWdata <= d;
    busWr <= w;
    busRd <= !w;
    do begin
      @(posedge core_clk);
      n++;
    end while (busWait !== 1'b0 && n < 50);
    q = busRdata;
    busWr <= 1'b0;
    busRd <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, junk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  function automatic logic [7:0] exp_byte(logic fx, int nbl, int bw, int blk, int i);
    logic [7:0] tab [8] = '{8'haa, 8'h33, 8'hf0, 8'h7f, 8'h55, 8'hcc, 8'h0f, 8'h80};
    int bar;
    bar = i / bw;
    if (bar > (1 << nbl) - 1) bar = (1 << nbl) - 1;
    if (fx) return (8'h30 + 8'(i % blk)) ^ (bar[0] ? 8'hff : 8'h00);
    return tab[bar * (8 >> nbl)];
  endfunction
  // Run one configuration, capture a frame, compare it beat by beat
  task automatic frame(input logic fx, input int nbl, input int bw, input int blk);
    tpg_beat_s b[$];
    int        t[$];
    int        n;
    int        k;
    tx_u.beats.delete();
    tx_u.stamp.delete();
    wr(REG_BAR_W, bw);
    wr(REG_BLK_SIZE, blk);
    wr(REG_CTRL, 32'((nbl << 2) | (fx << 1) | 1));
    n = 0;
    while (tx_u.beats.size() <= FB && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    wr(REG_CTRL, 32'h0);
    b = tx_u.beats;
    t = tx_u.stamp;
    chk({b[0].kind, b[0].wc}, {PK_FS, 16'h0000});
    k = 1;
    for (int l = 0; l < ACT; l++) begin
      chk({b[k].kind, b[k].vc, b[k].dt, b[k].wc}, {PK_HDR, 2'h2, 6'h24, 16'(LEN)});
      k++;
      for (int i = 0; i < LEN; i++) begin
        chk({b[k].kind, b[k].last, b[k].vc, b[k].dt, b[k].data},
            {PK_PAY, i == LEN - 1, 2'h2, 6'h24, exp_byte(fx, nbl, bw, blk, i)});
        k++;
      end
    end
    chk({b[k].kind, b[k].last, b[k].wc}, {PK_FE, 1'b1, 16'h0000});
    chk({b[k + 1].kind, b[k + 1].wc}, {PK_FS, 16'h0001});
    if (!stall) begin
      chk(t[1 + LEN + 1] - t[1], PD);
      chk(t[1] - t[0], PD);
      // Frame end skips the extra state that frame start passes through
      chk(t[k] - t[0], (1 + ACT + 1) * PD - 1);
      chk(t[k + 1] - t[0], TOT * PD);
    end
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk(REG_CTRL, 32'hc);
    rd_chk(REG_BLK_SIZE, 32'h1);
    rd_chk(8'h40, 32'h0);
    rd_chk(8'h3c, 32'h0);
    rd_chk(REG_STATUS, 32'h0);
    wr(REG_LINE_LEN, LEN);
    wr(REG_BAR_W, 32'h3);
    rd_chk(REG_LINE_LEN, LEN);
    rd_chk(REG_BAR_W, 32'h3);
    wr(REG_ACT_LPF, ACT);
    wr(REG_TOT_LPF, TOT);
    wr(REG_LINE_PD, PD);
    wr(REG_VBP, 32'h1);
    wr(REG_VFP, 32'h1);
    wr(REG_CSI, 32'ha4);
    for (int i = 0; i < 16; i++) wr(8'h40 + 8'(4 * i), 32'h30 + i);
    rd_chk(8'h7c, 32'h3f);
    frame(1'b0, 3, 3, 1);
    stall <= 1'b1;
    for (int nbl = 0; nbl < 3; nbl++) frame(1'b0, nbl, (9 >> nbl) * 3, 1);
    frame(1'b1, 1, 12, 3);
    frame(1'b1, 0, 27, 16);
    close_out();
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
